// file: rtl/cdx_core.sv
/*
 * cdx_core: decode and execute engine for the non-jump core instructions of a
 * 16-bit controller, with an APB slave for run control and state readout.
 * assumes: memory port answers each request with mem_ack; request held until then.
 */
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module cdx_core
	import cdx_pkg::*;
(
	input  wire logic        pclk,       // clock, 250 MHz
	input  wire logic        presetn,    // async reset, active low
	input  wire logic        psel,       // apb select
	input  wire logic        penable,    // apb access phase
	input  wire logic        pwrite,     // apb write
	input  wire logic [7:0]  paddr,      // apb byte address
	input  wire logic [31:0] pwdata,     // apb write data
	output logic      [31:0] prdata,     // apb read data
	output logic             pready,     // apb ready
	output logic             pslverr,    // apb error, unmapped address
	output logic             mem_req,    // memory request
	output logic             mem_we,     // memory write
	output logic             mem_byte,   // byte access
	output logic      [15:0] mem_addr,   // memory byte address
	output logic      [15:0] mem_wdata,  // memory write data
	input  wire logic [15:0] mem_rdata,  // memory read data
	input  wire logic        mem_ack     // memory answer
);
	cdx_state_type   state;
	logic [15:0]     pc;
	logic [15:0]     sp;
	logic [15:0]     sr;
	logic [15:0]     rf [4:15];
	logic [15:0]     ir;
	logic [15:0]     opnd;
	logic [15:0]     target;
	logic            is_call;
	logic            run;
	logic            fault;
	logic [15:0]     start_pc;
	logic [3:0]      reg_sel;
	wire             fmt1     = ir[15:12] >= OP_COPY;
	wire             fmt2     = ir[15:10] == FMT2_PREFIX;
	wire             is_jump  = ir[15:13] == JUMP_PREFIX;
	wire [2:0]       op2      = ir[9:7];
	wire             bw       = ir[6];                       // [RULE_05]
	wire [1:0]       src_addr_mode_field = ir[5:4];
	wire             dst_mode = ir[7];
	wire [3:0]       src_idx  = fmt1 ? ir[11:8] : ir[3:0];  // [RULE_06]
	wire [3:0]       dst_idx  = ir[3:0];                     // [RULE_06]
	// known single-operand codes; jumps are recognised but not executed here
	wire             fmt2_ok  = fmt2 && op2 <= OP_INTERRUPT_RETURN;                  // [RULE_07]
	wire             known_op = fmt1 || fmt2_ok || is_jump;                         // [RULE_07]
	function automatic logic [15:0] reg_value(input logic [3:0] idx);
		return idx == REG_PC ? pc : idx == REG_SP ? sp : idx == REG_SR ? sr : idx == REG_CG ? RST_WORD : rf[idx];
	endfunction : reg_value
	// constant generators cover some mode/register pairs without an extra word
	wire             const_gen_a = src_idx == REG_SR && src_addr_mode_field[1];     // [RULE_02]
	wire             const_gen_b = src_idx == REG_CG;                                // [RULE_02]
	wire [15:0]      cg_a_val = src_addr_mode_field[0] ? 16'h0008 : 16'h0004;
	wire [15:0]      cg_b_val = src_addr_mode_field == AM_REG   ? 16'h0000 :
	                            src_addr_mode_field == AM_INDEX ? 16'h0001 :
	                            src_addr_mode_field == AM_IND   ? 16'h0002 : 16'hffff;
	wire             imm_src  = src_addr_mode_field == AM_IND_INC && src_idx == REG_PC; // [RULE_01]
	wire             plain_reg = src_addr_mode_field == AM_REG;
	wire             op_needs_src = fmt1 || (fmt2 && (op2 == OP_PUSH || op2 == OP_CALL));
	wire             src_ok   = plain_reg || const_gen_a || const_gen_b || imm_src;
	// immediate/constant on an operand that is written back is a destination use
	wire             dst_imm  = fmt2 && !op_needs_src && op2 != OP_INTERRUPT_RETURN &&
	                            !plain_reg;                                            // [RULE_03]
	wire             bad_mode = (fmt1 && dst_mode) || !src_ok || dst_imm;            // [RULE_03]
	wire             dec_fault = !known_op || is_jump || bad_mode;
	wire [15:0]      src_val  = const_gen_a ? cg_a_val : const_gen_b ? cg_b_val : reg_value(src_idx);
	wire [15:0]      dst_val  = reg_value(dst_idx);
	logic [15:0] res;
	logic        wb;
	logic        upd;
	logic        fv;
	logic        fc;
	logic [16:0] sum;
	logic [15:0] addend;
	logic        cin;
	logic [4:0]  nib;
	logic        dc;
	logic        dcb;
	wire [15:0] mask = bw ? 16'h00ff : 16'hffff;
	wire        c_in = sr[SR_C];
	wire [15:0] am   = opnd & mask;
	wire [15:0] bm   = dst_val & mask;
	always_comb begin
		res    = RST_WORD;
		wb     = 1'b0;
		upd    = 1'b0;
		fv     = 1'b0;
		fc     = 1'b0;
		sum    = 17'h00000;
		addend = RST_WORD;
		cin    = 1'b0;
		nib    = 5'h00;
		dc     = c_in;
		dcb    = 1'b0;
		if (fmt1) begin
			case (ir[15:12])
				OP_SUM, OP_SUM_CARRY, OP_MINUS, OP_MINUS_BORROW, OP_COMPARE: begin
					addend = (ir[15:12] >= OP_MINUS_BORROW) ? (~opnd & mask) : am; // [RULE_09]
					cin    = (ir[15:12] == OP_SUM_CARRY || ir[15:12] == OP_MINUS_BORROW) ? c_in : // [RULE_08] [RULE_10]
					         (ir[15:12] == OP_SUM) ? 1'b0 : 1'b1; // [RULE_09]
					sum    = {1'b0, bm} + {1'b0, addend} + {16'h0000, cin};
					res    = sum[15:0] & mask;
					fc     = bw ? sum[8] : sum[16]; // [RULE_23]
					fv     = bw ? (bm[7] == addend[7] && res[7] != bm[7]) :
					              (bm[15] == addend[15] && res[15] != bm[15]); // [RULE_23]
					upd    = 1'b1; // [RULE_08]
					wb     = ir[15:12] != OP_COMPARE; // [RULE_11]
				end
				OP_DECIMAL_SUM: begin
					for (int i = 0; i < 4; i++) begin
						nib = {1'b0, am[4*i +: 4]} + {1'b0, bm[4*i +: 4]} + {4'h0, dc};
						dc  = nib > 5'd9;
						if (dc)
							nib = nib + 5'd6;
						res[4*i +: 4] = nib[3:0];
						if (i == 1)
							dcb = dc;
					end
					res = res & mask;
					fc  = bw ? dcb : dc; // [RULE_12]
					upd = 1'b1;
					wb  = 1'b1; // [RULE_12]
				end
				OP_BIT_TEST, OP_LOGIC_AND: begin
					res = am & bm; // [RULE_13]
					upd = 1'b1;
					fc  = res != RST_WORD; // [RULE_13]
					wb  = ir[15:12] == OP_LOGIC_AND; // [RULE_13]
				end
				OP_BIT_CLEAR: begin
					res = ~am & bm & mask; // [RULE_14]
					wb  = 1'b1;
				end
				OP_BIT_SET: begin
					res = am | bm; // [RULE_15]
					wb  = 1'b1;
				end
				OP_EXCL_OR: begin
					res = am ^ bm; // [RULE_16]
					fc  = res != RST_WORD;
					fv  = bw ? (am[7] & bm[7]) : (am[15] & bm[15]); // [RULE_16]
					upd = 1'b1;
					wb  = 1'b1;
				end
				default: begin
					res = am; // [RULE_15]
					wb  = 1'b1;
				end
			endcase
		end else begin
			case (op2)
				OP_ROTATE_CARRY: begin
					res = bw ? {8'h00, c_in, am[7:1]} : {c_in, am[15:1]}; // [RULE_17]
					fc  = am[0]; // [RULE_17]
					upd = 1'b1;
					wb  = 1'b1;
				end
				OP_SHIFT_ARITH: begin
					res = bw ? {8'h00, am[7], am[7:1]} : {am[15], am[15:1]}; // [RULE_18]
					fc  = am[0]; // [RULE_18]
					upd = 1'b1;
					wb  = 1'b1;
				end
				OP_SIGN_EXTEND: begin
					res = {{8{opnd[7]}}, opnd[7:0]}; // [RULE_22]
					fc  = res != RST_WORD;
					upd = 1'b1;
					wb  = 1'b1;
				end
				OP_BYTE_SWAP: begin
					res = {opnd[7:0], opnd[15:8]};
					wb  = 1'b1;
				end
				default: res = opnd;
			endcase
		end
	end
	// sign-extend and swap are always word wide
	wire        word_only = fmt2 && (op2 == OP_SIGN_EXTEND || op2 == OP_BYTE_SWAP);
	wire        use_byte  = bw && !word_only;
	wire        res_n     = use_byte ? res[7] : res[15];                                // [RULE_23]
	wire        res_z     = use_byte ? (res[7:0] == 8'h00) : (res == RST_WORD);
	// a byte result keeps the high byte of the target
	wire [15:0] wb_val    = use_byte ? {dst_val[15:8], res[7:0]} : res;                  // [RULE_23]
	wire [15:0] new_sr    = {sr[15:9], fv, sr[7:3], res_n, res_z, fc};
	wire [15:0] sp_dec    = sp - WORD_STEP;
	wire [15:0] sp_inc    = sp + WORD_STEP;
	wire [15:0] pc_inc    = pc + WORD_STEP;
	wire        apb_setup = psel && !penable;
	wire        apb_wr    = psel && penable && pwrite && pready;
	wire        hit_ctrl  = paddr == OFS_CTRL;
	wire        hit_start = paddr == OFS_START;
	wire        hit_stat  = paddr == OFS_STATUS;
	wire        hit_sel   = paddr == OFS_REG_SEL;
	wire        mapped    = paddr <= OFS_IR && paddr[1:0] == 2'b00;
	wire        fault_clr = apb_wr && hit_stat && pwdata[STAT_FAULT];
	wire [31:0] rd_mux = hit_ctrl  ? {31'h00000000, run} :
	                hit_start ? {16'h0000, start_pc} :
	                hit_stat  ? {24'h000000, state, 2'b00, fault, state != S_IDLE} :
	                (paddr == OFS_PC)       ? {16'h0000, pc} :
	                (paddr == OFS_SR)       ? {16'h0000, sr} :
	                (paddr == OFS_SP)       ? {16'h0000, sp} :
	                hit_sel   ? {28'h0000000, reg_sel} :
	                (paddr == OFS_REG_DATA) ? {16'h0000, reg_value(reg_sel)} :
	                (paddr == OFS_IR)       ? {16'h0000, ir} : 32'h00000000;
	// zero-wait slave: ready is raised for the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= apb_setup;
			pslverr <= apb_setup && !mapped;
			prdata  <= apb_setup ? rd_mux : 32'h00000000;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run      <= 1'b0;
			start_pc <= RST_START;
			reg_sel  <= 4'h0;
		end else if (apb_wr) begin
			if (hit_ctrl)
				run <= pwdata[0];
			if (hit_start)
				start_pc <= pwdata[15:0];
			if (hit_sel)
				reg_sel <= pwdata[3:0];
		end
	end
	// sequencer; a decode fault parks the engine until the fault bit is cleared by a status write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state     <= S_IDLE;
			pc        <= RST_START;
			sp        <= RST_WORD;
			sr        <= RST_WORD;
			ir        <= RST_WORD;
			opnd      <= RST_WORD;
			target    <= RST_WORD;
			is_call   <= 1'b0;
			fault     <= 1'b0;
			mem_req   <= 1'b0;
			mem_we    <= 1'b0;
			mem_byte  <= 1'b0;
			mem_addr  <= RST_WORD;
			mem_wdata <= RST_WORD;
			for (int i = 4; i < 16; i++)
				rf[i] <= RST_WORD;
		end else begin
			// fault set in this cycle wins over a clear
			if (fault_clr && !(state == S_DECODE && dec_fault))
				fault <= 1'b0;
			case (state)
				S_IDLE: begin
					if (run && !fault) begin
						pc       <= start_pc;
						mem_req  <= 1'b1;
						mem_addr <= start_pc;
						state    <= S_FETCH;
					end
				end
				S_FETCH: begin
					if (mem_ack) begin
						mem_req <= 1'b0;
						ir      <= mem_rdata;
						pc      <= pc_inc;
						state   <= S_DECODE;
					end
				end
				S_DECODE: begin
					if (dec_fault) begin
						fault <= 1'b1;
						state <= S_IDLE;
					end else if (imm_src && op_needs_src) begin
						mem_req  <= 1'b1;                                        // [RULE_04]
						mem_addr <= pc;                                          // [RULE_04]
						state    <= S_EXT;
					end else begin
						opnd  <= src_val;
						state <= S_EXEC;
					end
				end
				S_EXT: begin
					if (mem_ack) begin
						mem_req <= 1'b0;
						opnd    <= mem_rdata;                                    // [RULE_01]
						pc      <= pc_inc;                                       // [RULE_04]
						state   <= S_EXEC;
					end
				end
				S_EXEC: begin
					if (fmt2 && (op2 == OP_PUSH || op2 == OP_CALL)) begin
						sp        <= sp_dec;                                     // [RULE_19] [RULE_20]
						mem_req   <= 1'b1;
						mem_we    <= 1'b1;
						mem_addr  <= sp_dec;
						mem_byte  <= op2 == OP_PUSH && bw;
						mem_wdata <= op2 == OP_PUSH ? opnd : pc;                 // [RULE_19] [RULE_20]
						is_call   <= op2 == OP_CALL;
						target    <= opnd;
						state     <= S_WR;
					end else if (fmt2 && op2 == OP_INTERRUPT_RETURN) begin
						mem_req  <= 1'b1;                                        // [RULE_21]
						mem_addr <= sp;
						state    <= S_POPSR;
					end else begin
						if (upd)
							sr <= new_sr;                                        // [RULE_08] [RULE_16]
						if (wb) begin
							if (dst_idx == REG_PC)
								pc <= wb_val;
							else if (dst_idx == REG_SP)
								sp <= wb_val;
							else if (dst_idx == REG_SR)
								sr <= wb_val;
							else if (dst_idx != REG_CG)
								rf[dst_idx] <= wb_val;                           // [RULE_23]
						end
						state <= S_NEXT;
					end
				end
				S_WR: begin
					if (mem_ack) begin
						mem_req <= 1'b0;
						mem_we  <= 1'b0;
						mem_byte <= 1'b0;
						if (is_call)
							pc <= target;                                        // [RULE_20]
						state <= S_NEXT;
					end
				end
				S_POPSR: begin
					if (mem_ack) begin
						sr       <= mem_rdata;                                   // [RULE_21]
						sp       <= sp_inc;
						mem_addr <= sp_inc;
						state    <= S_POPPC;
					end
				end
				S_POPPC: begin
					if (mem_ack) begin
						mem_req <= 1'b0;
						pc      <= mem_rdata;                                    // [RULE_21]
						sp      <= sp_inc;                                       // [RULE_21]
						state   <= S_NEXT;
					end
				end
				default: begin
					if (run) begin
						mem_req  <= 1'b1;
						mem_addr <= pc;
						state    <= S_FETCH;
					end else begin
						state <= S_IDLE;
					end
				end
			endcase
		end
	end
endmodule : cdx_core
`default_nettype wire

// file: rtl/cdx_pkg.sv
/*
 * cdx_pkg: constants for the 16-bit core decode/execute block: opcodes,
 * status bit positions, engine states, register offsets and reset values.
 * assumes: one clock domain, imported whole by the cdx_core module.
 */
// Summary of operation
// [RULE_01] immediate source instructions take an extra word right after the opcode
// [RULE_02] constant generator values need no extra word, instruction is one word shorter
// [RULE_03] immediate mode is legal only as source, never as destination
// [RULE_04] immediate fetch reads word at program counter, then counter steps past it
// [RULE_05] size bit 0 means word operation, 1 means byte operation
// [RULE_06] source found by mode field plus register, destination likewise
// [RULE_07] decoder knows all 27 core opcodes; emulated forms need nothing extra
// [RULE_08] add-with-carry adds carry, plain add does not; both set V N Z C
// [RULE_09] subtract is dst plus inverted src plus one, sets V N Z C
// [RULE_10] subtract-with-borrow is dst plus inverted src plus carry, sets V N Z C
// [RULE_11] compare computes like subtract but never writes the destination
// [RULE_12] decimal add sums src, dst and carry in packed BCD, sets V N Z C
// [RULE_13] bit-test and AND compute src AND dst; V cleared; only AND stores
// [RULE_14] bit-clear stores inverted src AND dst, flags untouched
// [RULE_15] bit-set stores src OR dst, flags untouched, as copy does
// [RULE_16] exclusive-or stores src XOR dst and sets V N Z C
// [RULE_17] rotate right through carry: old carry into MSB, LSB into carry
// [RULE_18] arithmetic shift right keeps MSB, LSB into carry, V cleared
// [RULE_19] push lowers stack pointer by two, then writes source there
// [RULE_20] call lowers stack pointer by two, stores return address, loads target
// [RULE_21] interrupt return pops status then counter, stack pointer up two each
// [RULE_22] sign-extend copies bit 7 into bits 8 to 15, V cleared
// [RULE_23] byte operations take flags from bit 7 and write only the low byte
package cdx_pkg;

	typedef enum logic [3:0] {
		S_IDLE   = 4'b0000,
		S_FETCH  = 4'b0001,
		S_DECODE = 4'b0010,
		S_EXT    = 4'b0011,
		S_EXEC   = 4'b0100,
		S_WR     = 4'b0101,
		S_POPSR  = 4'b0110,
		S_POPPC  = 4'b0111,
		S_NEXT   = 4'b1000
	} cdx_state_type;

	// double-operand opcodes, instruction bits 15:12
	localparam logic [3:0] OP_COPY          = 4'h4;
	localparam logic [3:0] OP_SUM           = 4'h5;
	localparam logic [3:0] OP_SUM_CARRY     = 4'h6;
	localparam logic [3:0] OP_MINUS_BORROW  = 4'h7;
	localparam logic [3:0] OP_MINUS         = 4'h8;
	localparam logic [3:0] OP_COMPARE       = 4'h9;
	localparam logic [3:0] OP_DECIMAL_SUM   = 4'ha;
	localparam logic [3:0] OP_BIT_TEST      = 4'hb;
	localparam logic [3:0] OP_BIT_CLEAR     = 4'hc;
	localparam logic [3:0] OP_BIT_SET       = 4'hd;
	localparam logic [3:0] OP_EXCL_OR       = 4'he;
	localparam logic [3:0] OP_LOGIC_AND     = 4'hf;
	// single-operand group prefix (bits 15:10) and sub-opcodes (bits 9:7)
	localparam logic [5:0] FMT2_PREFIX      = 6'h04;
	localparam logic [2:0] OP_ROTATE_CARRY  = 3'h0;
	localparam logic [2:0] OP_BYTE_SWAP     = 3'h1;
	localparam logic [2:0] OP_SHIFT_ARITH   = 3'h2;
	localparam logic [2:0] OP_SIGN_EXTEND   = 3'h3;
	localparam logic [2:0] OP_PUSH          = 3'h4;
	localparam logic [2:0] OP_CALL          = 3'h5;
	localparam logic [2:0] OP_INTERRUPT_RETURN = 3'h6;
	// jump group prefix, bits 15:13
	localparam logic [2:0] JUMP_PREFIX      = 3'h1;

	// addressing modes of the source mode field
	localparam logic [1:0] AM_REG           = 2'h0;
	localparam logic [1:0] AM_INDEX         = 2'h1;
	localparam logic [1:0] AM_IND           = 2'h2;
	localparam logic [1:0] AM_IND_INC       = 2'h3;
	localparam logic [3:0] REG_PC           = 4'h0;
	localparam logic [3:0] REG_SP           = 4'h1;
	localparam logic [3:0] REG_SR           = 4'h2;
	localparam logic [3:0] REG_CG           = 4'h3;

	// status_reg bit positions
	localparam int SR_C = 0;
	localparam int SR_Z = 1;
	localparam int SR_N = 2;
	localparam int SR_V = 8;

	localparam logic [15:0] WORD_STEP       = 16'h0002;

	// software register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL         = 8'h00;
	localparam logic [7:0] OFS_START        = 8'h04;
	localparam logic [7:0] OFS_STATUS       = 8'h08;
	localparam logic [7:0] OFS_PC           = 8'h0c;
	localparam logic [7:0] OFS_SR           = 8'h10;
	localparam logic [7:0] OFS_SP           = 8'h14;
	localparam logic [7:0] OFS_REG_SEL      = 8'h18;
	localparam logic [7:0] OFS_REG_DATA     = 8'h1c;
	localparam logic [7:0] OFS_IR           = 8'h20;
	localparam int STAT_BUSY  = 0;
	localparam int STAT_FAULT = 1;

	localparam logic [15:0] RST_START       = 16'h0000;
	localparam logic [15:0] RST_WORD        = 16'h0000;

endpackage : cdx_pkg

// file: tb/cdx_core_properties.sv
/* cdx_core_props: port checks of cdx_core, APB slave and memory port.
   assumes: bound into cdx_core, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module cdx_core_props (
	input wire logic        pclk,      // clock
	input wire logic        presetn,   // reset
	input wire logic        psel,      // select
	input wire logic        penable,   // access
	input wire logic [7:0]  paddr,     // address
	input wire logic [31:0] prdata,    // read data
	input wire logic        pready,    // ready
	input wire logic        pslverr,   // error
	input wire logic        mem_req,   // request
	input wire logic        mem_we,    // write
	input wire logic        mem_byte,  // byte
	input wire logic [15:0] mem_addr,  // address
	input wire logic [15:0] mem_wdata, // data
	input wire logic        mem_ack    // answer
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_one_cycle_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	ready_after_setup_a: assert property (psel && !penable |=> pready)
		else $error("no ready in access");
	ready_in_access_a: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data not zero");
	error_decode_a: assert property (psel && !penable |=> pslverr == ($past(paddr) > 8'h20 || $past(paddr) % 4 != 0))
		else $error("error flag wrong");
	request_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable({mem_addr, mem_we, mem_wdata}))
		else $error("request changed before answer");
	write_release_a: assert property (mem_req && mem_ack && mem_we |=> !mem_req)
		else $error("write request not released");
	byte_write_only_a: assert property (mem_req && mem_byte |-> mem_we)
		else $error("byte access on read");
	pop_step_a: assert property (mem_req && mem_ack && !mem_we ##1 mem_req |-> mem_addr == $past(mem_addr) + 16'h2)
		else $error("second pop not two above");
endmodule : cdx_core_props
bind cdx_core cdx_core_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_byte(mem_byte),
	.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack));
`default_nettype wire

// file: tb/cdx_mem.sv
/* cdx_mem: program and data memory answering after 0..max_wait stall cycles.
   assumes: bench preloads mem; aligned words, byte addresses, low byte first. */
`timescale 1ns/1ps
`default_nettype none
module cdx_mem (
	input  wire logic        pclk,      // clock
	input  wire logic        presetn,   // reset
	input  wire logic        mem_req,   // request
	input  wire logic        mem_we,    // write
	input  wire logic        mem_byte,  // byte
	input  wire logic [15:0] mem_addr,  // address
	input  wire logic [15:0] mem_wdata, // data
	input  wire logic [1:0]  max_wait,  // stall cap
	output logic      [15:0] mem_rdata, // read data
	output logic             mem_ack    // answer
);
	logic [7:0] mem [0:65535];
	logic [1:0] wait_cnt;
	// data toggles when not answering so a stale word never looks valid
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_ack <= 1'b0;
			wait_cnt <= 2'h0;
			mem_rdata <= 16'h0;
		end else if (mem_req && !mem_ack && wait_cnt == 2'h0) begin
			mem_ack <= 1'b1;
			mem_rdata <= {mem[mem_addr | 16'h1], mem[mem_addr]};
			if (mem_we) begin
				mem[mem_addr] <= mem_wdata[7:0];
				if (!mem_byte) mem[mem_addr | 16'h1] <= mem_wdata[15:8];
			end
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			wait_cnt <= mem_ack ? (2'($random) & max_wait) : wait_cnt - {1'b0, mem_req};
		end
	end
endmodule : cdx_mem
`default_nettype wire

// file: tb/cdx_core_tb_top.sv
/* cdx_core_tb_top: random and directed programs run through APB, results read back.
   assumes: cdx_mem as memory; a jump word ends each program with a fault. */
`timescale 1ns/1ps
`default_nettype none
module cdx_core_tb_top
	import cdx_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_req, mem_we, mem_byte, mem_ack, bw, c, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q, x;
	logic [15:0] mem_addr, mem_wdata, mem_rdata, a, b, at;
	logic [15:0] stk [18];
	logic [2:0] subs [4];
	logic [1:0] max_wait;
	int num_errors, checked, seed, k;
	cdx_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we),
		.mem_byte(mem_byte), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
	cdx_mem u_mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_we(mem_we), .mem_byte(mem_byte),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .max_wait(max_wait), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	task automatic test_done;
		if (num_errors == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : test_done
	task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
		checked++;
		if (got !== ex) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, got);
		end
	endtask : check
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] r, output logic er);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		check("pready", 32'h1, n);
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		logic [31:0] r;
		logic er;
		apb(1'b1, ad, d, r, er);
	endtask : wr
	task automatic rd(input logic [7:0] ad, output logic [31:0] r);
		logic er;
		apb(1'b0, ad, 32'h0, r, er);
	endtask : rd
	task automatic getr(input logic [3:0] n, output logic [31:0] r);
		wr(OFS_REG_SEL, {28'h0, n});
		rd(OFS_REG_DATA, r);
	endtask : getr
	task automatic put(input logic [15:0] w);
		u_mem.mem[at] = w[7:0];
		u_mem.mem[at + 16'h1] = w[15:8];
		at += 16'h2;
	endtask : put
	task automatic run(input logic [15:0] st);
		logic [31:0] r;
		int n;
		wr(OFS_START, {16'h0, st});
		wr(OFS_CTRL, 32'h1);
		r = 32'h0;
		for (n = 0; n < 100 && r[STAT_FAULT] !== 1'b1; n++) rd(OFS_STATUS, r);
		wr(OFS_CTRL, 32'h0);
		wr(OFS_STATUS, 32'h2);
	endtask : run
	// k 0..11 double-operand from copy up, 12..15 rotate, swap, shift, sign-extend; returns {status, dst}
	function automatic logic [31:0] ref_exec(input int k, input logic bw, input logic [15:0] s, d, input logic c);
		logic [16:0] t;
		logic [15:0] r, y, m, sr;
		logic v, cy, upd;
		int hi;
		hi = bw ? 7 : 15;
		m = bw ? 16'h00ff : 16'hffff;
		sr = {15'h0, c};
		y = (k > 2 && k < 6) ? ~s & m : s & m;
		r = 16'h0;
		v = 1'b0;
		cy = 1'b0;
		upd = !(k == 0 || k == 8 || k == 9 || k == 13);
		case (k)
			0: r = y;
			1, 2, 3, 4, 5: begin
				t = (d & m) + y + ((k == 1) ? 1'b0 : (k > 3) ? 1'b1 : c);
				r = t[15:0] & m;
				v = (d[hi] == y[hi]) && (r[hi] != d[hi]);
				cy = t[hi + 1];
			end
			6: begin
				cy = c;
				for (int i = 0; i <= hi; i += 4) begin
					t = s[i+:4] + d[i+:4] + cy;
					cy = t > 9;
					r[i+:4] = cy ? 4'(t - 10) : 4'(t);
				end
			end
			7, 11: r = y & d;
			8: r = ~y & d & m;
			9: r = (y | d) & m;
			10: r = (y ^ d) & m;
			12: r = ({15'h0, c} << hi) | ((d & m) >> 1);
			13: r = {d[7:0], d[15:8]};
			14: r = (d & m & (16'h1 << hi)) | ((d & m) >> 1);
			default: r = {{8{d[7]}}, d[7:0]};
		endcase
		if (k == 7 || k == 10 || k == 11 || k == 15) cy = r != 16'h0;
		if (k == 10) v = y[hi] & d[hi];
		if (k == 12 || k == 14) cy = d[0];
		if (upd) sr = {7'h0, v, 5'h0, r[hi], r == 16'h0, cy};
		r = (k == 5 || k == 7) ? d : bw ? {d[15:8], r[7:0]} : r;
		return {sr, r};
	endfunction : ref_exec
	initial begin
		#160000;
		num_errors++;
		test_done();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, max_wait} = '0;
		num_errors = 0;
		checked = 0;
		seed = 32471;
		subs = '{OP_ROTATE_CARRY, OP_BYTE_SWAP, OP_SHIFT_ARITH, OP_SIGN_EXTEND};
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(OFS_START, q);
		check("start reset", 32'h0, q);
		wr(OFS_SP, 32'h1234);
		rd(OFS_SP, q);
		check("sp read-only", 32'h0, q);
		apb(1'b0, 8'h24, 32'h0, q, e);
		check("unmapped", 32'h1, {q[30:0], e});
		for (int i = 0; i < 48; i++) begin
			k = (i < 16) ? i : ($random(seed) & 15);
			a = 16'($random(seed));
			b = (i % 4 == 3) ? 16'h7fff : 16'($random(seed));
			c = 1'($random(seed));
			bw = (k == 13 || k == 15) ? 1'b0 : 1'($random(seed));
			max_wait <= 2'(i);
			for (int j = 0; j < 16 && k == 6; j += 4) begin
				a[j+:4] = a[j+:4] % 4'ha;
				b[j+:4] = b[j+:4] % 4'ha;
			end
			at = 16'h0200;
			put(16'h4034);
			put(a);
			put(16'h4035);
			put(b);
			put(16'h4032);
			put({15'h0, c});
			put(k < 12 ? {OP_COPY + 4'(k), 4'h4, 1'b0, bw, 6'h05} : {FMT2_PREFIX, subs[k[1:0]], bw, 6'h05});
			put(16'h3fff);
			run(16'h0200);
			x = ref_exec(k, bw, a, b, c);
			getr(4'h5, q);
			check("dst", {16'h0, x[15:0]}, q);
			rd(OFS_SR, q);
			check("status", {16'h0, x[31:16]}, q);
		end
		stk = '{16'h4031, 16'h0400, 16'h1270, 16'h00a5, 16'h1230, 16'h0120, 16'h1230, 16'h0105, 16'h12b0,
			16'h0118, 16'h3fff, 16'h3fff, 16'h4031, 16'h03fa, 16'h1300, 16'h3fff, 16'h3fff, 16'h3fff};
		at = 16'h0100;
		foreach (stk[i]) put(stk[i]);
		run(16'h0100);
		rd(OFS_SP, q);
		check("sp", 32'h03fe, q);
		rd(OFS_SR, q);
		check("popped status", 32'h0105, q);
		check("byte push", 32'h00a5, {24'h0, u_mem.mem[16'h03fe]});
		check("return addr", 32'h0114, {16'h0, u_mem.mem[16'h03f9], u_mem.mem[16'h03f8]});
		at = 16'h0300;
		put(16'h4335);
		put(16'h5325);
		put(16'h3fff);
		run(16'h0300);
		getr(4'h5, q);
		check("const dst", 32'h0001, q);
		rd(OFS_SR, q);
		check("const status", 32'h0001, q);
		test_done();
	end
endmodule : cdx_core_tb_top
`default_nettype wire
